//--- rtl/bspd_detector.v
`timescale 1ns/1ns
`default_nettype none
`include "bspd_consts.vh"
// ****************************************
// sixteen-channel bell pulse detector
// ****************************************
module bspd_detector (
   input  wire        sys_clk,
   input  wire        resetn,
   input  wire [15:0] sensor_n,
   input  wire [7:0]  cmd_data,
   input  wire        cmd_valid,
   input  wire [15:0] chan_enable,
   input  wire        test_mode,
   input  wire [31:0] debounce_us,
   input  wire        debounce_load,
   input  wire [31:0] guard_us,
   input  wire        guard_load,
   output reg  [7:0]  tx_data,
   output reg         tx_valid,
   input  wire        tx_ready,
   output reg  [3:0]  scan_chan,
   output reg         scan_wrap,
   output reg         fifo_full,
   output reg  [7:0]  last_cmd
);
   // ****************************************
   // reset release and helpers
   // ****************************************
   reg  [1:0]  rst_pipe;
   wire        rst_n = rst_pipe[1];
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rst_pipe <= 2'h0;
      end else begin
         rst_pipe <= {rst_pipe[0], 1'b1};
      end
   end

   // wrap-safe "deadline reached": signed difference not negative
   function reached;
      input [31:0] now;
      input [31:0] dl;
      reg   [31:0] diff;
      begin
         diff    = now - dl;
         reached = ~diff[31];
      end
   endfunction

   function [7:0] bell_char;
      input [3:0] ch;
      begin
         case (ch)
            4'h9:    bell_char = 8'h30;
            4'hA:    bell_char = 8'h45;
            4'hB:    bell_char = 8'h54;
            4'hC:    bell_char = 8'h41;
            4'hD:    bell_char = 8'h42;
            4'hE:    bell_char = 8'h43;
            4'hF:    bell_char = 8'h44;
            default: bell_char = 8'h31 + {4'h0, ch};
         endcase
      end
   endfunction

   // ****************************************
   // input synchroniser
   // ****************************************
   wire [15:0] sens;
   bspd_sync #(.WIDTH(`BSPD_NCH)) u_sync (
      .clk   (sys_clk),
      .rst_n (rst_n),
      .d     (sensor_n),
      .q     (sens)
   );

   // ****************************************
   // microsecond time base and settings
   // ****************************************
   localparam [7:0]  TICK_MAX  = `BSPD_TICK_CYC - 1;
   localparam [15:0] VISIT_MAX = `BSPD_VISIT_CYC - 1;
   reg  [7:0]  tick_cnt;
   reg  [31:0] now_us;
   reg  [31:0] debounce;
   reg  [31:0] guard;
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_cnt <= 8'h00;
         now_us   <= 32'h0000_0000;
         debounce <= `BSPD_DEBOUNCE_US;
         guard    <= `BSPD_GUARD_US;
         last_cmd <= 8'h00;
      end else begin
         if (tick_cnt == TICK_MAX) begin
            tick_cnt <= 8'h00;
            now_us   <= now_us + 32'h1; // wraps freely
         end else begin
            tick_cnt <= tick_cnt + 8'h01;
         end
         if (debounce_load) begin
            debounce <= debounce_us;
         end
         if (guard_load) begin
            guard <= guard_us;
         end
         if (cmd_valid) begin
            last_cmd <= cmd_data;
         end
      end
   end

   // ****************************************
   // scan highest enabled channel
   // ****************************************
   reg [3:0] top_chan;
   integer   i;
   always @* begin
      top_chan = 4'h0;
      for (i = 0; i < `BSPD_NCH; i = i + 1) begin
         if (chan_enable[i]) begin
            top_chan = i[3:0];
         end
      end
   end

   // ****************************************
   // channel state storage and scan
   // ****************************************
   reg  [2:0]  st    [0:15];
   reg  [31:0] dl    [0:15];
   reg  [15:0] last_lvl;
   reg  [15:0] visit_cnt;
   reg         test_lat;
   reg  [3:0]  test_idx;
   reg  [7:0]  push_data;
   reg         push_valid;
   wire        push_ready;
   wire        visit = (visit_cnt == VISIT_MAX) && !(push_valid && !push_ready);
   wire [2:0]  cur   = st[scan_chan];
   wire        lvl   = sens[scan_chan];
   integer     k;

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (k = 0; k < `BSPD_NCH; k = k + 1) begin
            st[k] <= `BSPD_ST_INPUT;
            dl[k] <= 32'h0000_0000;
         end
         last_lvl   <= 16'hFFFF;
         visit_cnt  <= 16'h0000;
         scan_chan  <= 4'h0;
         scan_wrap  <= 1'b0;
         test_lat   <= 1'b0;
         test_idx   <= 4'h0;
         push_data  <= 8'h00;
         push_valid <= 1'b0;
      end else begin
         scan_wrap <= 1'b0;
         if (push_valid && push_ready) begin
            push_valid <= 1'b0;
         end
         if (test_mode) begin
            test_lat <= 1'b1;
         end
         if (visit_cnt != VISIT_MAX) begin
            visit_cnt <= visit_cnt + 16'h0001;
         end else if (visit) begin
            visit_cnt <= 16'h0000;
            if (scan_chan >= top_chan) begin
               scan_chan <= 4'h0;
               scan_wrap <= 1'b1;
            end else begin
               scan_chan <= scan_chan + 4'h1;
            end
            if (test_lat) begin
               st[scan_chan] <= `BSPD_ST_TEST;
               if (scan_chan == 4'h0) begin
                  push_data  <= `BSPD_TEST_CHAR0 + {4'h0, test_idx};
                  push_valid <= 1'b1;
                  test_idx   <= (test_idx == 4'h8) ? 4'h0 : test_idx + 4'h1;
               end
            end else if (!chan_enable[scan_chan]) begin
               st[scan_chan] <= `BSPD_ST_DISABLED;
               last_lvl[scan_chan] <= lvl;
            end else begin
               case (cur)
                  `BSPD_ST_INPUT: begin
                     last_lvl[scan_chan] <= lvl;
                     if (last_lvl[scan_chan] && !lvl) begin
                        dl[scan_chan] <= now_us + debounce;
                        st[scan_chan] <= `BSPD_ST_DEBOUNCE;
                     end
                  end
                  `BSPD_ST_DEBOUNCE: begin
                     if (lvl) begin
                        st[scan_chan]       <= `BSPD_ST_INPUT;
                        last_lvl[scan_chan] <= 1'b1;
                     end else if (reached(now_us, dl[scan_chan])) begin
                        push_data     <= bell_char(scan_chan);
                        push_valid    <= 1'b1;
                        dl[scan_chan] <= now_us + guard;
                        st[scan_chan] <= `BSPD_ST_GUARD;
                     end
                     // otherwise remain here
                  end
                  `BSPD_ST_GUARD: begin
                     if (reached(now_us, dl[scan_chan])) begin
                        st[scan_chan]       <= `BSPD_ST_INPUT;
                        last_lvl[scan_chan] <= 1'b0;
                     end
                  end
                  `BSPD_ST_DISABLED: begin
                     st[scan_chan]       <= `BSPD_ST_INPUT;
                     last_lvl[scan_chan] <= lvl;
                  end
                  default: begin
                     st[scan_chan] <= `BSPD_ST_INPUT;
                  end
               endcase
            end
         end
      end
   end

   // ****************************************
   // character queue and output stage
   // ****************************************
   wire [7:0] q_data;
   wire       q_valid;
   wire       q_ready = !tx_valid || tx_ready;
   bspd_fifo #(.WIDTH(8), .DEPTH(`BSPD_FIFO_DEPTH), .AW(4)) u_fifo (
      .clk       (sys_clk),
      .rst_n     (rst_n),
      .in_data   (push_data),
      .in_valid  (push_valid),
      .in_ready  (push_ready),
      .out_data  (q_data),
      .out_valid (q_valid),
      .out_ready (q_ready)
   );
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_data   <= 8'h00;
         tx_valid  <= 1'b0;
         fifo_full <= 1'b0;
      end else begin
         fifo_full <= !push_ready;
         if (q_ready) begin
            tx_valid <= q_valid;
            tx_data  <= q_data;
         end
      end
   end
endmodule
`default_nettype wire

//--- rtl/bspd_consts.vh
`ifndef BSPD_CONSTS_VH
`define BSPD_CONSTS_VH
`define BSPD_CLK_MHZ        250
`define BSPD_NCH            16
`define BSPD_TIME_W         32
`define BSPD_DEBOUNCE_US    2000
`define BSPD_GUARD_US       100000
`define BSPD_PASS_US        400
// cycles per channel visit, so a sixteen-channel pass lasts the pass time
`define BSPD_VISIT_CYC      ((`BSPD_PASS_US * `BSPD_CLK_MHZ) / `BSPD_NCH)
`define BSPD_TICK_CYC       `BSPD_CLK_MHZ
`define BSPD_ST_INPUT       3'h0
`define BSPD_ST_DEBOUNCE    3'h1
`define BSPD_ST_GUARD       3'h2
`define BSPD_ST_DISABLED    3'h3
`define BSPD_ST_TEST        3'h4
`define BSPD_FIFO_DEPTH     16
`define BSPD_TEST_CHAR0     8'h31
`endif

//--- rtl/bspd_fifo.v
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// small synchronous fifo
// ****************************************
module bspd_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   input  wire             clk,
   input  wire             rst_n,
   input  wire [WIDTH-1:0] in_data,
   input  wire             in_valid,
   output wire             in_ready,
   output wire [WIDTH-1:0] out_data,
   output wire             out_valid,
   input  wire             out_ready
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wr_ptr;
   reg [AW-1:0]    rd_ptr;
   reg [AW:0]      count;
   wire            do_wr;
   wire            do_rd;
   assign in_ready  = (count != DEPTH[AW:0]);
   assign out_valid = (count != {(AW+1){1'b0}});
   assign out_data  = mem[rd_ptr];
   assign do_wr     = in_valid & in_ready;
   assign do_rd     = out_valid & out_ready;
   always @(posedge clk) begin
      if (do_wr) begin
         mem[wr_ptr] <= in_data;
      end
   end
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count  <= {(AW+1){1'b0}};
      end else begin
         if (do_wr) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (do_rd) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         if (do_wr && !do_rd) begin
            count <= count + 1'b1;
         end else if (do_rd && !do_wr) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

//--- rtl/bspd_sync.v
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// two-stage synchroniser, vector wide
// ****************************************
module bspd_sync #(
   parameter WIDTH = 16
) (
   input  wire             clk,
   input  wire             rst_n,
   input  wire [WIDTH-1:0] d,
   output reg  [WIDTH-1:0] q
);
   reg [WIDTH-1:0] meta;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= {WIDTH{1'b1}};
         q    <= {WIDTH{1'b1}};
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule
`default_nettype wire

//--- tb/bspd_detector_sva.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// port checker
// ****************************************
module bspd_chk (
   input wire logic        sys_clk,
   input wire logic        resetn,
   input wire logic [7:0]  cmd_data,
   input wire logic        cmd_valid,
   input wire logic [15:0] chan_enable,
   input wire logic [7:0]  tx_data,
   input wire logic        tx_valid,
   input wire logic        tx_ready,
   input wire logic [3:0]  scan_chan,
   input wire logic        scan_wrap,
   input wire logic [7:0]  last_cmd
);
   logic [15:0] gap;
   logic        seen;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   // cycles since the previous end of pass
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         gap <= 16'h0000;
         seen <= 1'b0;
      end else if (scan_wrap) begin
         gap <= 16'h0001;
         seen <= 1'b1;
      end else begin
         gap <= gap + 16'h0001;
      end
   end
   AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
      else $error("tx char changed before accept");
   AST_TX_DROP: assert property ($fell(tx_valid) |-> $past(tx_ready))
      else $error("tx valid dropped without accept");
   AST_CMD_CAPTURE: assert property (cmd_valid |=> last_cmd == $past(cmd_data))
      else $error("command char not captured");
   AST_WRAP_PULSE: assert property (scan_wrap |=> !scan_wrap [*8])
      else $error("end of pass not a single pulse");
   AST_PASS_TIME: assert property (scan_wrap && seen && chan_enable == 16'h0001
      |-> gap inside {[16'h1865:16'h186F]})
      else $error("pass time off");
   AST_SCAN_RANGE: assert property (chan_enable == 16'h0001 |-> scan_chan == 4'h0)
      else $error("disabled channel visited");
   AST_RESET_QUIET: assert property ($rose(resetn) |-> (!tx_valid && !scan_wrap) [*3])
      else $error("activity right after reset");
   AST_CHAR_SET: assert property (tx_valid
      |-> tx_data inside {[8'h30:8'h39], 8'h45, 8'h54, [8'h41:8'h44]})
      else $error("illegal char sent");
endmodule
bind bspd_detector bspd_chk i_chk (
   .sys_clk     (sys_clk),
   .resetn      (resetn),
   .cmd_data    (cmd_data),
   .cmd_valid   (cmd_valid),
   .chan_enable (chan_enable),
   .tx_data     (tx_data),
   .tx_valid    (tx_valid),
   .tx_ready    (tx_ready),
   .scan_chan   (scan_chan),
   .scan_wrap   (scan_wrap),
   .last_cmd    (last_cmd)
);
`default_nettype wire

//--- tb/bspd_sensor_model.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// sensor chain model
// ****************************************
module bspd_sensor_model (
   input  wire logic        sys_clk,
   output var  logic [15:0] sensor_n
);
   initial sensor_n = 16'hFFFF; // idle high
   // drive one channel after a falling clock edge
   task automatic set_level(input int ch, input logic lvl);
      @(negedge sys_clk);
      sensor_n[ch] = lvl; // drive the requested level, low or high
   endtask
   // pulse held low for a number of clock cycles
   task automatic pulse(input int ch, input int cyc);
      set_level(ch, 1'b0);
      repeat (cyc) @(negedge sys_clk); // pulse length
      sensor_n[ch] = 1'b1;
   endtask
endmodule
`default_nettype wire

//--- tb/bspd_detector_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "bspd_consts.vh"
// ****************************************
// testbench
// ****************************************
module bspd_detector_tb;
   logic        sys_clk = 1'b0;
   logic        resetn = 1'b0;
   logic [15:0] sensor_n;
   logic [7:0]  cmd_data = 8'h00;
   logic        cmd_valid = 1'b0;
   logic        test_mode = 1'b0;
   logic [31:0] debounce_us = 32'h0000000A;
   logic        debounce_load = 1'b0;
   logic [31:0] guard_us = 32'h0000001E;
   logic        guard_load = 1'b0;
   logic        tx_ready = 1'b0;
   logic [7:0]  tx_data, last_cmd;
   logic        tx_valid, scan_wrap, fifo_full;
   logic [3:0]  scan_chan;
   int          n_mismatch = 0;
   int          comparisons = 0;
   int          cyc = 0;
   bspd_detector i_dut (
      .sys_clk(sys_clk), .resetn(resetn), .sensor_n(sensor_n), .cmd_data(cmd_data),
      .cmd_valid(cmd_valid), .chan_enable(16'h0001), .test_mode(test_mode),
      .debounce_us(debounce_us), .debounce_load(debounce_load), .guard_us(guard_us),
      .guard_load(guard_load), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
      .scan_chan(scan_chan), .scan_wrap(scan_wrap), .fifo_full(fifo_full), .last_cmd(last_cmd));
   bspd_sensor_model i_sens (.sys_clk(sys_clk), .sensor_n(sensor_n));
   initial forever #2 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 100000) begin
         n_mismatch = n_mismatch + 1;
         finish_test();
      end
   end
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      comparisons = comparisons + 1;
      if (got !== exp) begin
         n_mismatch = n_mismatch + 1;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // wait for a char under a bound, 8'hFF when none comes
   task automatic wait_tx(input int max, output logic [7:0] c);
      c = 8'hFF;
      repeat (max) begin
         @(negedge sys_clk);
         if (tx_valid === 1'b1) begin
            c = tx_data;
            return;
         end
      end
   endtask
   task automatic t_confirm;
      logic [7:0] c;
      i_sens.set_level(0, 1'b0);
      wait_tx(20000, c);
      chk8(c, 8'h31);
      repeat (5) @(negedge sys_clk);
      chk8({7'h00, tx_valid}, 8'h01);
      chk8({7'h00, fifo_full}, 8'h00);
      tx_ready = 1'b1;
      @(negedge sys_clk);
      wait_tx(20000, c);
      chk8(c, 8'hFF);
      i_sens.set_level(0, 1'b1);
      wait_tx(7000, c);
      chk8(c, 8'hFF);
   endtask
   task automatic t_misfire;
      logic [7:0] c;
      i_sens.pulse(0, 6250);
      wait_tx(13000, c);
      chk8(c, 8'hFF);
   endtask
   task automatic t_cmd;
      cmd_data = 8'h5A;
      cmd_valid = 1'b1;
      @(negedge sys_clk);
      cmd_valid = 1'b0;
      @(negedge sys_clk);
      chk8(last_cmd, 8'h5A);
   endtask
   task automatic t_test;
      logic [7:0] c;
      test_mode = 1'b1;
      i_sens.set_level(0, 1'b0);
      wait_tx(14000, c);
      chk8(c, `BSPD_TEST_CHAR0);
      @(negedge sys_clk);
      wait_tx(14000, c);
      chk8(c, `BSPD_TEST_CHAR0 + 8'h01);
   endtask
   task automatic finish_test;
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      repeat (3) @(negedge sys_clk);
      resetn = 1'b1;
      repeat (3) @(negedge sys_clk);
      debounce_load = 1'b1; // short periods keep the run brief
      guard_load = 1'b1;
      @(negedge sys_clk);
      debounce_load = 1'b0;
      guard_load = 1'b0;
      t_cmd();
      t_confirm();
      t_misfire();
      t_test();
      finish_test();
   end
endmodule
`default_nettype wire
